//--- design/nfh_host.sv
// host sequencer driving a byte wide nand flash over its strobe pins
`default_nettype none
module nfh_host
    import nfh_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_req,
    input  wire nfh_pkg::nfh_op_t    i_op,
    input  wire logic [15:0]         i_row,
    input  wire logic [9:0]          i_col,
    input  wire logic [9:0]          i_len,
    input  wire logic                i_wp_allow,
    input  wire logic                i_wvalid,
    input  wire logic [7:0]          i_wdata,
    input  wire logic [7:0]          i_dq_in,
    input  wire logic                i_rb,
    output logic                     o_ready,
    output logic                     o_wready,
    output logic                     o_rvalid,
    output logic [7:0]               o_rdata,
    output logic                     o_done,
    output logic                     o_timeout,
    output logic [7:0]               o_dq_out,
    output logic                     o_dq_oe,
    output logic                     o_ce_n,
    output logic                     o_cle,
    output logic                     o_ale,
    output logic                     o_wr_n,
    output logic                     o_output_strobe_n,
    output logic                     o_wp_n
);
    import nfh_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CMD   = 3'b001,
        S_ADDR  = 3'b010,
        S_WDATA = 3'b011,
        S_CMD2  = 3'b100,
        S_WAIT  = 3'b101,
        S_RDATA = 3'b110,
        S_END   = 3'b111
    } nfh_st_t;

    typedef struct packed {
        nfh_st_t          st;
        nfh_op_t          op;
        logic [15:0]      row;
        logic [9:0]       col;
        logic [9:0]       left;
        logic [1:0]       anum;
        logic [23:0]      tmo;
        logic [4:0]       settle;
        logic             go;
        logic             gord;
        logic             pend;
        logic [7:0]       dq_out;
        logic             dq_oe;
        logic             ce_n;
        logic             cle;
        logic             ale;
        logic             ready;
        logic             wready;
        logic             rvalid;
        logic             done;
        logic             timeout;
        logic             wp_n;
        logic [7:0]       dq_s1;
        logic [7:0]       dq_s2;
        logic             rb_s1;
        logic             rb_s2;
    } nfh_host_t;

    nfh_host_t h_q, h_d;
    logic       stb_done;
    logic [7:0] stb_rdata;

    // first command byte for each operation
    function automatic logic [7:0] first_cmd(input nfh_op_t op, input logic [9:0] col);
        unique case (op)
            NFH_OP_READ:   first_cmd = (col >= 10'(HALF_PAGE)) ? CMD_READ_B : CMD_READ_A;
            NFH_OP_PROG:   first_cmd = CMD_PROG;
            NFH_OP_ERASE:  first_cmd = CMD_ERASE;
            NFH_OP_STATUS: first_cmd = CMD_STATUS;
            NFH_OP_RESET:  first_cmd = CMD_RESET;
            NFH_OP_ID:     first_cmd = CMD_READ_ID;
            NFH_OP_SPARE:  first_cmd = CMD_READ_SP;
            NFH_OP_COPY:   first_cmd = CMD_READ_A;
        endcase
    endfunction : first_cmd

    // number of address bytes, zero for single byte commands
    function automatic logic [1:0] addr_bytes(input nfh_op_t op);
        unique case (op)
            NFH_OP_ERASE:                  addr_bytes = 2'd2;
            NFH_OP_STATUS, NFH_OP_RESET:   addr_bytes = 2'd0;
            NFH_OP_ID:                     addr_bytes = 2'd1;
            default:                       addr_bytes = 2'd3;
        endcase
    endfunction : addr_bytes

    always_comb begin
        h_d        = h_q;
        h_d.go     = 1'b0;
        h_d.rvalid = 1'b0;
        h_d.done   = 1'b0;
        h_d.wready = 1'b0;
        h_d.dq_s1  = i_dq_in;
        h_d.dq_s2  = h_q.dq_s1;
        h_d.rb_s1  = i_rb;
        h_d.rb_s2  = h_q.rb_s1;
        h_d.wp_n   = i_wp_allow;
        if (h_q.settle != 5'h0) begin
            h_d.settle = h_q.settle - 5'h1;
        end
        unique case (h_q.st)
            S_IDLE: begin
                h_d.ready = h_q.rb_s2;
                // while busy only reset and status may start
                if (i_req && (h_q.rb_s2 || i_op == NFH_OP_RESET || i_op == NFH_OP_STATUS)) begin
                    h_d.st     = S_CMD;
                    h_d.op     = i_op;
                    h_d.row    = i_row;
                    h_d.col    = i_col;
                    h_d.left   = i_len;
                    h_d.anum   = 2'd0;
                    h_d.ready  = 1'b0;
                    h_d.ce_n   = 1'b0;
                    h_d.cle    = 1'b1;
                    h_d.dq_out = first_cmd(i_op, i_col);
                    h_d.dq_oe  = 1'b1;
                    h_d.go     = 1'b1;
                    h_d.gord   = 1'b0;
                    h_d.pend   = 1'b0;
                end
            end
            S_CMD, S_ADDR, S_CMD2: begin
                if (stb_done) begin
                    h_d.cle = 1'b0;
                    if (h_q.anum != addr_bytes(h_q.op)) begin
                        h_d.st     = S_ADDR;
                        h_d.ale    = 1'b1;
                        h_d.go     = 1'b1;
                        h_d.anum   = h_q.anum + 2'd1;
                        if (h_q.op == NFH_OP_ERASE || h_q.anum == 2'd1) begin
                            h_d.dq_out = (h_q.op == NFH_OP_ERASE && h_q.anum == 2'd0) ? h_q.row[7:0] :
                                         (h_q.anum == 2'd1 && h_q.op != NFH_OP_ERASE) ? h_q.row[7:0] :
                                         h_q.row[15:8];
                        end else if (h_q.anum == 2'd0) begin
                            h_d.dq_out = (h_q.op == NFH_OP_ID) ? 8'h00 : h_q.col[7:0];
                        end else begin
                            h_d.dq_out = h_q.row[15:8];
                        end
                    end else begin
                        h_d.ale = 1'b0;
                        // copy waits for the array fetch before its confirm byte
                        if (h_q.st == S_CMD2 || h_q.op == NFH_OP_RESET || h_q.op == NFH_OP_COPY) begin
                            h_d.st     = S_WAIT;
                            h_d.dq_oe  = 1'b0;
                            h_d.settle = 5'(BUSY_SETTLE_CYC);
                            h_d.tmo    = 24'(BUSY_TIMEOUT_CYC);
                        end else if (h_q.op == NFH_OP_PROG) begin
                            h_d.st   = S_WDATA;
                            h_d.pend = 1'b0;
                        end else if (h_q.op == NFH_OP_ERASE) begin
                            h_d.st     = S_CMD2;
                            h_d.cle    = 1'b1;
                            h_d.dq_out = (h_q.op == NFH_OP_ERASE) ? CMD_ERASE_GO : CMD_COPY_GO;
                            h_d.go     = 1'b1;
                        end else begin
                            // page and spare reads: the array fetch raises busy first; id and status read at once
                            h_d.st     = (h_q.op == NFH_OP_READ || h_q.op == NFH_OP_SPARE) ? S_WAIT : S_RDATA;
                            h_d.dq_oe  = 1'b0;
                            h_d.settle = 5'(BUSY_SETTLE_CYC);
                            h_d.tmo    = 24'(RANDOM_ACCESS_US * 1000 / CLK_PERIOD_NS);
                        end
                    end
                end
            end
            S_WDATA: begin
                if (h_q.left == 10'h0) begin
                    if (!h_q.pend || stb_done) begin
                        h_d.st     = S_CMD2;
                        h_d.cle    = 1'b1;
                        h_d.dq_out = CMD_PROG_GO;
                        h_d.go     = 1'b1;
                        h_d.anum   = addr_bytes(h_q.op);
                    end
                end else if (h_q.wready && i_wvalid) begin
                    h_d.dq_out = i_wdata;
                    h_d.go     = 1'b1;
                    h_d.pend   = 1'b1;
                    h_d.left   = h_q.left - 10'h1;
                end else if (!h_q.pend || stb_done) begin
                    h_d.wready = 1'b1;
                    h_d.pend   = 1'b0;
                end
            end
            S_WAIT: begin
                h_d.tmo = h_q.tmo - 24'h1;
                if (h_q.settle == 5'h0 && h_q.rb_s2 && h_q.op == NFH_OP_COPY && !h_q.pend) begin
                    h_d.st     = S_CMD2;
                    h_d.cle    = 1'b1;
                    h_d.dq_out = CMD_COPY_GO;
                    h_d.dq_oe  = 1'b1;
                    h_d.go     = 1'b1;
                    h_d.pend   = 1'b1;
                end else if (h_q.settle == 5'h0 && h_q.rb_s2) begin
                    h_d.st = (h_q.op == NFH_OP_READ || h_q.op == NFH_OP_SPARE) ? S_RDATA : S_END;
                end else if (h_q.tmo == 24'h0) begin
                    h_d.timeout = 1'b1;
                    h_d.st      = S_END;
                end
            end
            S_RDATA: begin
                if (h_q.gord && stb_done) begin
                    h_d.rvalid = 1'b1;
                    h_d.gord   = 1'b0;
                end else if (!h_q.gord && !h_q.rvalid) begin
                    if (h_q.left == 10'h0) begin
                        h_d.st = S_END;
                    end else begin
                        h_d.go   = 1'b1;
                        h_d.gord = 1'b1;
                        h_d.left = h_q.left - 10'h1;
                    end
                end
            end
            S_END: begin
                h_d.ce_n = 1'b1;
                h_d.done = 1'b1;
                h_d.st   = S_IDLE;
            end
        endcase
        if (h_q.st != S_WAIT && h_d.st == S_IDLE) begin
            h_d.timeout = h_q.timeout && !i_req;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            h_q      <= '0;
            h_q.ce_n <= 1'b1;
            h_q.st   <= S_IDLE;
        end else begin
            h_q <= h_d;
        end
    end

    nfh_strobe u_strobe (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_go      (h_q.go),
        .i_rd      (h_q.gord),
        .i_dq_sync (h_q.dq_s2),
        .o_wr_n    (o_wr_n),
        .o_rd_n    (o_output_strobe_n),
        .o_done    (stb_done),
        .o_rdata   (stb_rdata)
    );

    assign o_ready   = h_q.ready;
    assign o_wready  = h_q.wready;
    assign o_rvalid  = h_q.rvalid;
    assign o_rdata   = stb_rdata;
    assign o_done    = h_q.done;
    assign o_timeout = h_q.timeout;
    assign o_dq_out  = h_q.dq_out;
    assign o_dq_oe   = h_q.dq_oe;
    assign o_ce_n    = h_q.ce_n;
    assign o_cle     = h_q.cle;
    assign o_ale     = h_q.ale;
    assign o_wp_n    = h_q.wp_n;

    ////////////////////////////////////////////////////////////////////////////
    a_no_contention: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_output_strobe_n |-> !o_dq_oe) else $error("host drives port during read");
    a_latch_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
        !(o_cle && o_ale)) else $error("both latch strobes high");
    a_cmd_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_wr_n) && o_cle |-> $stable(o_dq_out) && o_dq_oe) else $error("command moved at latch");
    a_addr_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_wr_n) && o_ale |-> $stable(o_dq_out) && !o_cle) else $error("address moved at latch");
    a_busy_cmds: assert property (@(posedge i_clk) disable iff (i_rst)
        h_q.st == S_IDLE && h_d.st == S_CMD && !h_q.rb_s2 |->
        ##1 (o_dq_out == CMD_RESET || o_dq_out == CMD_STATUS)) else $error("command while busy");
    a_wp_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_wp_allow |=> !o_wp_n) else $error("write guard not applied");
endmodule : nfh_host
`default_nettype wire

//--- pkg/nfh_pkg.sv
// constants and types shared by the nand flash host port controller
`default_nettype none
package nfh_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // strobe timing (half cycles of a byte transfer used by the host, and the full read cycle)
    localparam int unsigned STROBE_LOW_NS  = 25;
    localparam int unsigned STROBE_HIGH_NS = 25;
    localparam int unsigned READ_CYCLE_NS  = 50;
    localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_CYCLE_CYC  = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest busy wait we tolerate before flagging a timeout
    localparam int unsigned RANDOM_ACCESS_US = 15;
    localparam int unsigned BUSY_TIMEOUT_US  = 10000;
    localparam int unsigned BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    // ready pin may lag the last write strobe; wait before trusting it
    localparam int unsigned BUSY_SETTLE_NS  = 100;
    localparam int unsigned BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PAGE_BYTES      = 528;
    localparam int unsigned HALF_PAGE       = 256;
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned COL_W           = 10;

    localparam logic [7:0] CMD_READ_A   = 8'h00;
    localparam logic [7:0] CMD_READ_B   = 8'h01;
    localparam logic [7:0] CMD_READ_SP  = 8'h50;
    localparam logic [7:0] CMD_READ_ID  = 8'h90;
    localparam logic [7:0] CMD_RESET    = 8'hff;
    localparam logic [7:0] CMD_PROG     = 8'h80;
    localparam logic [7:0] CMD_PROG_GO  = 8'h10;
    localparam logic [7:0] CMD_COPY_GO  = 8'h8a;
    localparam logic [7:0] CMD_ERASE    = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_STATUS   = 8'h70;

    // operation codes accepted on the user port
    typedef enum logic [2:0] {
        NFH_OP_READ   = 3'b000,
        NFH_OP_PROG   = 3'b001,
        NFH_OP_ERASE  = 3'b010,
        NFH_OP_STATUS = 3'b011,
        NFH_OP_RESET  = 3'b100,
        NFH_OP_ID     = 3'b101,
        NFH_OP_SPARE  = 3'b110,
        NFH_OP_COPY   = 3'b111
    } nfh_op_t;

    // byte kinds placed on the port by the sequencer
    typedef enum logic [1:0] {
        NFH_BK_CMD  = 2'b00,
        NFH_BK_ADDR = 2'b01,
        NFH_BK_DATA = 2'b10
    } nfh_bk_t;

    localparam logic [2:0] ST_IDLE = 3'd0;
endpackage : nfh_pkg
`default_nettype wire

//--- design/nfh_strobe.sv
// one write or read strobe pulse generator with byte capture
`default_nettype none
module nfh_strobe
    import nfh_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_dq_sync,
    output logic            o_wr_n,
    output logic            o_rd_n,
    output logic            o_done,
    output logic [7:0]      o_rdata
);
    import nfh_pkg::*;

    typedef struct packed {
        logic       busy;
        logic       rd;
        logic       phase;
        logic [3:0] cnt;
        logic       wr_n;
        logic       rd_n;
        logic       done;
        logic [7:0] rdata;
    } nfh_stb_t;

    nfh_stb_t s_q, s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy) begin
            if (i_go) begin
                s_d.busy  = 1'b1;
                s_d.rd    = i_rd;
                s_d.phase = 1'b0;
                s_d.cnt   = 4'(STROBE_LOW_CYC - 1);
                // byte is latched by the device on the rising edge only
                s_d.wr_n  = i_rd;
                s_d.rd_n  = !i_rd;
            end
        end else if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;
        end else if (!s_q.phase) begin
            // sampled late in the low phase, two sync stages already in the path
            if (s_q.rd) begin
                s_d.rdata = i_dq_sync;
            end
            s_d.wr_n  = 1'b1;
            s_d.rd_n  = 1'b1;
            s_d.phase = 1'b1;
            s_d.cnt   = 4'(STROBE_HIGH_CYC - 1);
        end else begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{busy: 1'b0, rd: 1'b0, phase: 1'b0, cnt: 4'h0, wr_n: 1'b1, rd_n: 1'b1,
                     done: 1'b0, rdata: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_wr_n  = s_q.wr_n;
    assign o_rd_n  = s_q.rd_n;
    assign o_done  = s_q.done;
    assign o_rdata = s_q.rdata;

    a_pulse_width: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_rd_n) |-> !o_rd_n [*5] ##1 o_rd_n) else $error("read strobe low time wrong");
    a_write_width: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_wr_n) |-> !o_wr_n [*5] ##1 o_wr_n [*5]) else $error("write strobe timing wrong");
endmodule : nfh_strobe
`default_nettype wire

//--- test/nfh_flash_model.sv
// behavioural flash device on the far side of the host port
`default_nettype none
module nfh_flash_model #(
    parameter int unsigned PROG_NS = 2000,
    parameter int unsigned LOAD_NS = 1500,
    parameter logic [7:0]  ID_CODE = 8'h3c // arbitrary value
) (
    input  wire logic       i_ce_n,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic       i_wr_n,
    input  wire logic       i_out_strobe_n,
    input  wire logic       i_wp_n,
    input  wire logic [7:0] i_dq,
    output logic [7:0]      o_dq,
    output logic            o_dq_oe,
    output logic            o_busy,
    output logic [7:0]      o_viol
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem[int];
    logic [7:0] page[int];
    logic [7:0] adr[3];
    logic [7:0] cmd_q = 8'h00;
    logic [7:0] v;
    int         n_adr = 0;
    int         col = 0;
    int         row = 0;
    realtime    t_fall = -100.0;

    initial begin
        o_busy = 1'b0;
        o_dq = 8'h00;
        o_dq_oe = 1'b0;
        o_viol = 8'h00;
    end

    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
    endfunction : rd

    // runs detached, so status polls and deselect cannot cut it short
    task automatic hold_busy(input int unsigned ns, input int kind);
        int b;
        b = (row & ~31) * 528;
        o_busy = 1'b1;
        #(ns);
        if (i_wp_n && kind == 1) foreach (page[c]) mem[row * 528 + c] = page[c];
        if (i_wp_n && kind == 2) for (int a = b; a < b + 32 * 528; a++) mem[a] = 8'hff;
        o_busy = 1'b0;
    endtask : hold_busy

    ////////////////////////////////////////
    always @(posedge i_wr_n) begin
        if (!i_ce_n && i_cle) begin
            if (o_busy && i_dq != 8'hff && i_dq != 8'h70) o_viol = o_viol + 8'h01;
            n_adr = 0;
            if (i_dq == 8'h10) fork hold_busy(PROG_NS, 1); join_none
            else if (i_dq == 8'h8a) fork hold_busy(PROG_NS, 0); join_none
            else if (i_dq == 8'hd0) fork hold_busy(2 * PROG_NS, 2); join_none
            else if (i_dq == 8'hff) fork hold_busy(100, 0); join_none
            else cmd_q = i_dq;
            if (i_dq == 8'h80) page.delete();
        end else if (!i_ce_n && i_ale && n_adr < 3) begin
            adr[n_adr] = i_dq;
            n_adr++;
            if (cmd_q == 8'h60 && n_adr == 2) row = {adr[1], adr[0]};
            if (cmd_q == 8'h90) col = 0;
            else if (n_adr == 3 && cmd_q != 8'h60) begin
                row = {adr[2], adr[1]};
                col = (cmd_q == 8'h50) ? 512 + adr[0][3:0] : (cmd_q == 8'h01 ? 256 : 0) + adr[0];
                if (cmd_q != 8'h80) fork hold_busy(LOAD_NS, 0); join_none
            end
        end else if (!i_ce_n && !i_ale) begin
            page[col] = i_dq;
            col++;
        end
    end

    always @(negedge i_out_strobe_n) begin
        if (!i_ce_n) begin
            if ($realtime - t_fall < 50.0) o_viol = o_viol + 8'h01;
            t_fall = $realtime;
            v = (cmd_q == 8'h70) ? {i_wp_n, !o_busy, 6'h00} : (cmd_q == 8'h90) ? ID_CODE + col[7:0] : rd(row * 528 + col);
            col++;
            o_dq <= #8 v;
            o_dq_oe <= #8 1'b1;
        end
    end

    always @(posedge i_out_strobe_n or posedge i_ce_n) o_dq_oe <= #4 1'b0;
endmodule : nfh_flash_model
`default_nettype wire

//--- test/tb_nand_flash_host_port.sv
// self-checking bench: host port controller against the flash model
`default_nettype none
module tb_nand_flash_host_port;
    timeunit 1ns;
    timeprecision 1ps;
    import nfh_pkg::*;
    localparam int CYC_LIMIT = 60000;
    logic i_clk, i_rst, i_req, i_wp_allow, i_wvalid, i_rb;
    nfh_op_t i_op;
    logic [15:0] i_row;
    logic [9:0] i_col, i_len;
    logic [7:0] i_wdata, i_dq_in, o_dq_out, o_rdata, dev_dq, dq_last, viol;
    logic o_ready, o_wready, o_rvalid, o_done, o_timeout, o_dq_oe, dev_oe, busy;
    logic o_ce_n, o_cle, o_ale, o_wr_n, o_output_strobe_n, o_wp_n;
    logic [7:0] exp_q[$];
    logic [7:0] wbuf[$];
    logic [7:0] img[int];
    int err_total, samples_checked, cyc, k, r, c;
    integer seed;

    // released port shows the inverse of its last level, never a stale copy
    assign i_dq_in = o_dq_oe ? o_dq_out : (dev_oe ? dev_dq : ~dq_last);
    assign i_rb = ~busy;

    nfh_host dut_u (.i_clk, .i_rst, .i_req, .i_op, .i_row, .i_col, .i_len, .i_wp_allow, .i_wvalid,
        .i_wdata, .i_dq_in, .i_rb, .o_ready, .o_wready, .o_rvalid, .o_rdata, .o_done, .o_timeout,
        .o_dq_out, .o_dq_oe, .o_ce_n, .o_cle, .o_ale, .o_wr_n, .o_output_strobe_n, .o_wp_n);

    nfh_flash_model #(.ID_CODE(8'h3c)) flash_u (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
        .i_wr_n(o_wr_n), .i_out_strobe_n(o_output_strobe_n), .i_wp_n(o_wp_n), .i_dq(i_dq_in),
        .o_dq(dev_dq), .o_dq_oe(dev_oe), .o_busy(busy), .o_viol(viol));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    function automatic logic [7:0] exp_byte(input int a);
        return img.exists(a) ? img[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
    endfunction : exp_byte

    task automatic expect_rd(input int row, input int col, input int len);
        for (int i = 0; i < len; i++) exp_q.push_back(exp_byte(row * 528 + col + i));
    endtask : expect_rd

    task automatic run_op(input string name, input nfh_op_t op, input int row, input int col, input int len);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 9000) begin
            @(posedge i_clk);
            n++;
        end
        @(posedge i_clk);
        i_op <= op;
        i_row <= row[15:0];
        i_col <= col[9:0];
        i_len <= len[9:0];
        i_wvalid <= (op == NFH_OP_PROG);
        i_wdata <= wbuf[0];
        i_req <= 1'b1;
        @(posedge i_clk);
        i_req <= 1'b0;
        k = 0;
        while (o_done !== 1'b1 && n < 9000) begin
            @(posedge i_clk);
            n++;
            if (o_wready === 1'b1 && i_wvalid === 1'b1) begin
                k++;
                i_wdata <= wbuf[k % wbuf.size()];
            end
        end
        i_wvalid <= 1'b0;
        if (n >= 9000) chk("op completion", 8'h00, 8'h01);
        $display("test %s done", name);
    endtask : run_op

    task automatic prog(input string name, input int row, input int len, input logic wp);
        i_wp_allow <= wp;
        wbuf.delete();
        for (int i = 0; i < len; i++) begin
            wbuf.push_back(8'($random(seed)));
            if (wp) img[row * 528 + i] = wbuf[i];
        end
        run_op(name, NFH_OP_PROG, row, 0, len);
    endtask : prog

    ////////////////////////////////////////
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_dq_oe | dev_oe) dq_last <= i_dq_in;
        if (o_rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk("surplus read byte", o_rdata, ~o_rdata);
            else chk("read byte", o_rdata, exp_q.pop_front());
        end
        if (cyc == CYC_LIMIT) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        seed = 32'h32455582;
        i_rst = 1'b1;
        {i_req, i_wvalid, i_row, i_col, i_len, i_wdata, dq_last} = '0;
        i_op = NFH_OP_READ;
        i_wp_allow = 1'b1;
        wbuf = '{8'h00};
        {err_total, samples_checked, cyc} = '0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        run_op("reset", NFH_OP_RESET, 0, 0, 0);
        prog("program", 40, 16, 1'b1);
        expect_rd(40, 0, 16);
        run_op("read back", NFH_OP_READ, 40, 0, 16);
        expect_rd(77, 300, 6);
        run_op("upper half", NFH_OP_READ, 77, 300, 6);
        expect_rd(77, 515, 4);
        run_op("spare", NFH_OP_SPARE, 77, 3, 4);
        prog("guarded program", 41, 8, 1'b0);
        i_wp_allow <= 1'b1;
        expect_rd(41, 0, 8);
        run_op("guarded read", NFH_OP_READ, 41, 0, 8);
        for (int a = 32 * 528; a < 64 * 528; a++) img[a] = 8'hff;
        run_op("erase", NFH_OP_ERASE, 40, 0, 0);
        expect_rd(40, 0, 8);
        run_op("erased", NFH_OP_READ, 40, 0, 8);
        expect_rd(63, 520, 8);
        run_op("erased tail", NFH_OP_READ, 63, 520, 8);
        exp_q.push_back(8'hc0);
        run_op("status", NFH_OP_STATUS, 0, 0, 1);
        exp_q.push_back(8'h3c);
        exp_q.push_back(8'h3d);
        run_op("ident", NFH_OP_ID, 0, 0, 2);
        run_op("copy", NFH_OP_COPY, 90, 0, 0);
        repeat (4) begin
            r = {$random(seed)} % 65536;
            c = {$random(seed)} % 512;
            expect_rd(r, c, 4);
            run_op("random read", NFH_OP_READ, r, c, 4);
        end
        repeat (20) @(posedge i_clk);
        chk("device protocol flags", viol, 8'h00);
        chk("busy timeout", {7'h00, o_timeout}, 8'h00);
        chk("missing read bytes", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule : tb_nand_flash_host_port
`default_nettype wire
